// ==== rtl/pin_sync.sv ====
/*
 Two flip-flop synchroniser for one asynchronous pin, plus a registered copy
 of the synchronised level for edge detection. Assumes clk_sys_i is far faster
 than the pin toggles.
*/
`timescale 1ns/1ps
module pin_sync
   import sipo_latch_pkg::*;
#(
   parameter logic RESET_LEVEL = 1'h0
)
(
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic pin_i,
   output logic level_o,
   output logic prev_o
);

   logic meta_reg;

   // The first stage feeds only the second one.
   always_ff @(posedge clk_sys_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         meta_reg <= RESET_LEVEL;
         level_o <= RESET_LEVEL;
         prev_o <= RESET_LEVEL;
      end
      else
      begin
         meta_reg <= pin_i;
         level_o <= meta_reg;
         prev_o <= level_o;
      end
   end

endmodule

// ==== rtl/serial_in_parallel_out_latch.sv ====
/*
 Serial-in parallel-out shift register with a storage register and
 tri-statable parallel outputs, all sampled on clk_sys_i. Assumes the
 controller's clocks and clear are slow against clk_sys_i (each pin level
 holds at least two system cycles) and that the bench resolves the
 three-state outputs from the enables.
*/
`timescale 1ns/1ps
module serial_in_parallel_out_latch
   import sipo_latch_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire ctrl_pins_s ctrl_i,
   output par_pins_s par_o,
   output logic cascade_serial_out_o
);

   ////////////////////////////////////////////////////////////////////////////
   localparam int PIN_COUNT = $bits(ctrl_pins_s);
   logic [PIN_COUNT-1:0] raw;
   logic [PIN_COUNT-1:0] lvl;
   logic [PIN_COUNT-1:0] prv;
   localparam logic [PIN_COUNT-1:0] SYNC_RESET = {PIN_RESET, PIN_RESET, PIN_IDLE_HIGH, PIN_RESET, PIN_IDLE_HIGH};

   assign raw = ctrl_i;

   genvar g;
   generate
      for (g = 0; g < PIN_COUNT; g++)
      begin : g_sync
         pin_sync #(.RESET_LEVEL(SYNC_RESET[g])) u_sync (
            .clk_sys_i(clk_sys_i),
            .rst_i(rst_i),
            .pin_i(raw[g]),
            .level_o(lvl[g]),
            .prev_o(prv[g])
         );
      end
   endgenerate

   ctrl_pins_s now_s;
   ctrl_pins_s old_s;
   assign now_s = lvl;
   assign old_s = prv;

   logic shift_rise;
   logic store_rise;
   assign shift_rise = now_s.shift_clock & ~old_s.shift_clock;
   assign store_rise = now_s.storage_clock & ~old_s.storage_clock;

   ////////////////////////////////////////////////////////////////////////////
   stage_t shift_reg;
   stage_t store_reg;

   always_ff @(posedge clk_sys_i or posedge rst_i)
   begin
      if (rst_i)
         shift_reg <= STAGE_RESET;
      else if (!now_s.shift_clear_n)
         shift_reg <= STAGE_RESET;
      else if (shift_rise)
         shift_reg <= {shift_reg[STAGES-2:0], now_s.serial_data_in};
   end

   always_ff @(posedge clk_sys_i or posedge rst_i)
   begin
      if (rst_i)
         store_reg <= STAGE_RESET;
      else if (store_rise)
         store_reg <= shift_reg;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Storage register drives outputs.
   // Cascade from final stage.
   // Outputs lag the storage register by one cycle so they leave a flip-flop.
   always_ff @(posedge clk_sys_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         par_o.parallel_outputs <= STAGE_RESET;
         par_o.parallel_oe <= OUT_ENABLE_OFF;
         cascade_serial_out_o <= PIN_RESET;
      end
      else
      begin
         par_o.parallel_outputs <= store_reg;
         par_o.parallel_oe <= now_s.output_enable_n ? OUT_ENABLE_OFF : OUT_ENABLE_ON;
         cascade_serial_out_o <= shift_reg[STAGES-1];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);

   // A shift edge only counts while the clear is released.
   sequence s_shift_edge;
      shift_rise && now_s.shift_clear_n;
   endsequence

   sequence s_shift_idle;
      !shift_rise && now_s.shift_clear_n;
   endsequence

   sequence s_shift_fall;
      !now_s.shift_clock && old_s.shift_clock && now_s.shift_clear_n;
   endsequence

   sequence s_clear_low;
      !now_s.shift_clear_n;
   endsequence

   sequence s_clear_shift;
      shift_rise && !now_s.shift_clear_n;
   endsequence

   sequence s_clear_only;
      !now_s.shift_clear_n && !store_rise;
   endsequence

   sequence s_store_edge;
      store_rise;
   endsequence

   sequence s_store_idle;
      !store_rise;
   endsequence

   sequence s_store_fall;
      !now_s.storage_clock && old_s.storage_clock;
   endsequence

   sequence s_tied_edge;
      shift_rise && store_rise && now_s.shift_clear_n;
   endsequence

   // Storage takes one cycle and the output flop one more, so data shows two cycles after the edge.
   sequence s_store_settle;
      s_store_edge ##1 1'h1;
   endsequence

   ////////////////////////////////////////////////////////////////////////////
   // Shift register.

   a_clear_zeroes: assert property (s_clear_low |=> shift_reg == STAGE_RESET)
      else $error("shift clear did not zero the stages");

   a_clear_wins: assert property (s_clear_shift |=> shift_reg == STAGE_RESET)
      else $error("shift edge overrode the clear");

   a_first_stage: assert property (s_shift_edge |=> shift_reg[0] == $past(now_s.serial_data_in))
      else $error("first stage missed serial data");

   a_stage_move: assert property (s_shift_edge |=> shift_reg[STAGES-1:1] == $past(shift_reg[STAGES-2:0]))
      else $error("stages did not move by one");

   a_shift_hold: assert property (s_shift_idle |=> $stable(shift_reg))
      else $error("shift register changed without its clock");

   a_shift_fall: assert property (s_shift_fall |=> $stable(shift_reg))
      else $error("shift register moved on a falling edge");

   ////////////////////////////////////////////////////////////////////////////
   // Storage register.

   a_store_copy: assert property (s_store_edge |=> store_reg == $past(shift_reg))
      else $error("storage copy wrong");

   a_store_hold: assert property (s_store_idle |=> $stable(store_reg))
      else $error("storage changed without its clock");

   a_store_fall: assert property (s_store_fall |=> $stable(store_reg))
      else $error("storage changed on a falling edge");

   a_clear_store: assert property (s_clear_only |=> $stable(store_reg))
      else $error("shift clear disturbed the storage register");

   a_tied_lag: assert property (s_tied_edge |=> store_reg == $past(shift_reg))
      else $error("tied clocks did not store the pre-shift contents");

   a_tied_ahead: assert property (s_tied_edge |=> shift_reg ==
      {$past(shift_reg[STAGES-2:0]), $past(now_s.serial_data_in)})
      else $error("tied clocks did not shift");

   ////////////////////////////////////////////////////////////////////////////
   // Pin outputs.

   a_out_enable: assert property (##1 par_o.parallel_oe ==
      ($past(now_s.output_enable_n) ? OUT_ENABLE_OFF : OUT_ENABLE_ON))
      else $error("output enable wrong");

   a_oe_uniform: assert property (par_o.parallel_oe == OUT_ENABLE_ON || par_o.parallel_oe == OUT_ENABLE_OFF)
      else $error("parallel enables disagree");

   a_reset_tristate: assert property (disable iff (1'h0) rst_i |=> par_o.parallel_oe == OUT_ENABLE_OFF)
      else $error("outputs driven during reset");

   a_cascade_tap: assert property (##1 cascade_serial_out_o == $past(shift_reg[STAGES-1]))
      else $error("cascade not from final stage");

   a_cascade_clear: assert property (s_clear_low |=> ##1 cascade_serial_out_o == PIN_RESET)
      else $error("cascade not cleared");

   a_out_follow: assert property (##1 par_o.parallel_outputs == $past(store_reg))
      else $error("parallel outputs not from storage");

   a_out_hold: assert property (s_store_idle |=> ##1 $stable(par_o.parallel_outputs))
      else $error("parallel outputs changed without a storage edge");

   a_out_data: assert property (s_store_settle |=> par_o.parallel_outputs == $past(shift_reg, 2))
      else $error("parallel outputs wrong after store");

endmodule

// ==== rtl/sipo_latch_pkg.sv ====
/*
 Package for the serial-in parallel-out latch: widths, reset values and the
 carrier structs for the pin groups. Assumes nothing of its surroundings.
*/
package sipo_latch_pkg;

   localparam int STAGES = 8;
   localparam int SYNC_DEPTH = 2;
   localparam logic [7:0] STAGE_RESET = 8'h00;
   localparam logic [7:0] OUT_ENABLE_ON = 8'hFF;
   localparam logic [7:0] OUT_ENABLE_OFF = 8'h00;
   localparam logic PIN_RESET = 1'h0;
   localparam logic PIN_IDLE_HIGH = 1'h1;

   typedef logic [STAGES-1:0] stage_t;

   // Raw pin levels driven by the controller.
   typedef struct packed {
      logic serial_data_in;
      logic shift_clock;
      logic shift_clear_n;
      logic storage_clock;
      logic output_enable_n;
   } ctrl_pins_s;

   // Parallel outputs split into level and per-pin enable.
   typedef struct packed {
      stage_t parallel_outputs;
      stage_t parallel_oe;
   } par_pins_s;

endpackage

// ==== test/ctrl_model.sv ====
/*
 Controller model that drives the latch pins at an 800 ns link rate.
 Assumes clk_sys_i runs at 100 ns and changes pins on its falling edge.
*/
`timescale 1ns/1ps
module ctrl_model
   import sipo_latch_pkg::*;
(
   input wire logic clk_sys_i,
   output ctrl_pins_s pins_o
);
   initial pins_o = 5'h05;
   ////////////////////////////////////////////////////////////
   // Rising clock pair.
   task automatic pulse(input logic d, input logic sh, input logic st);
      @(negedge clk_sys_i);
      pins_o.serial_data_in = d;
      repeat (2) @(negedge clk_sys_i);
      pins_o.shift_clock = sh;
      pins_o.storage_clock = st;
      repeat (4) @(negedge clk_sys_i);
      pins_o.shift_clock = 1'h0;
      pins_o.storage_clock = 1'h0;
      // Hold is over, so show the inverse rather than a stale level.
      pins_o.serial_data_in = ~d;
      @(negedge clk_sys_i);
   endtask
   task automatic set_pins(input logic clr_n, input logic oe_n);
      @(negedge clk_sys_i);
      pins_o.shift_clear_n = clr_n;
      pins_o.output_enable_n = oe_n;
      repeat (8) @(negedge clk_sys_i);
   endtask
endmodule

// ==== test/test_serial_in_parallel_out_latch.sv ====
/*
 Self-checking bench for the latch, driven through the controller model.
 Assumes the design sees every pin level for several system cycles.
*/
`timescale 1ns/1ps
module test_serial_in_parallel_out_latch;
   import sipo_latch_pkg::*;
   logic clk_sys_i = 1'h0;
   logic rst_i = 1'h1;
   ctrl_pins_s ctrl;
   par_pins_s par;
   logic cas;
   wire [7:0] q;
   int error_cnt = 0;
   int num_checks = 0;
   int cycles = 0;
   always #50 clk_sys_i = ~clk_sys_i;
   serial_in_parallel_out_latch i_serial_in_parallel_out_latch (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
      .ctrl_i(ctrl), .par_o(par), .cascade_serial_out_o(cas));
   ctrl_model i_ctrl_model (.clk_sys_i(clk_sys_i), .pins_o(ctrl));
   // Pins float wherever their enable is low.
   for (genvar b = 0; b < 8; b++)
      assign q[b] = par.parallel_oe[b] ? par.parallel_outputs[b] : 1'bz;
   ////////////////////////////////////////////////////////////
   task automatic chk(input logic [7:0] a, input logic [7:0] e);
      num_checks++;
      if (a !== e)
      begin
         error_cnt++;
         $display("MISMATCH t=%0t got %h want %h", $time, a, e);
      end
   endtask
   // Eight shift rises, first bit first.
   task automatic load(input logic [7:0] d);
      for (int i = 7; i >= 0; i--)
         i_ctrl_model.pulse(d[i], 1'h1, 1'h0);
   endtask
   task automatic t_load();
      i_ctrl_model.set_pins(1'h1, 1'h0);
      load(8'hA5);
      chk({7'h00, cas}, 8'h01);
      chk(q, 8'h00);
      i_ctrl_model.pulse(1'h0, 1'h0, 1'h1);
      chk(q, 8'hA5);
      $display("test load done");
   endtask
   task automatic t_tied();
      load(8'h3C);
      i_ctrl_model.pulse(1'h1, 1'h1, 1'h1);
      chk(q, 8'h3C);
      i_ctrl_model.pulse(1'h0, 1'h0, 1'h1);
      chk(q, 8'h79);
      $display("test tied done");
   endtask
   task automatic t_clear();
      i_ctrl_model.set_pins(1'h0, 1'h0);
      i_ctrl_model.pulse(1'h1, 1'h1, 1'h0);
      chk({7'h00, cas}, 8'h00);
      chk(q, 8'h79);
      i_ctrl_model.set_pins(1'h1, 1'h0);
      i_ctrl_model.pulse(1'h0, 1'h0, 1'h1);
      chk(q, 8'h00);
      i_ctrl_model.pulse(1'h1, 1'h1, 1'h0);
      i_ctrl_model.pulse(1'h0, 1'h0, 1'h1);
      chk(q, 8'h01);
      $display("test clear done");
   endtask
   task automatic t_oe();
      i_ctrl_model.set_pins(1'h1, 1'h1);
      chk(q, 8'hZZ);
      i_ctrl_model.set_pins(1'h1, 1'h0);
      chk(q, 8'h01);
      $display("test oe done");
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////
   // The whole run needs well under a thousand cycles.
   always @(posedge clk_sys_i)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         error_cnt++;
         $display("MISMATCH t=%0t timeout", $time);
         summarize();
      end
   end
   initial
   begin
      repeat (3) @(negedge clk_sys_i);
      rst_i = 1'h0;
      t_load();
      t_tied();
      t_clear();
      t_oe();
      summarize();
   end
endmodule
